// *** logic/loop_ctl_pkg.sv ***
/*
  Shared constants and types for the serial loop controller: register byte offsets,
  field positions, reset values, line patterns and the controller states.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package loop_ctl_pkg;

  localparam logic [4:0] OFF_LOOP_CONFIG = 5'h00;
  localparam logic [4:0] OFF_LOOP_STATUS = 5'h04;
  localparam logic [4:0] OFF_MAIN_STATUS = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK    = 5'h0c;
  localparam logic [4:0] OFF_TX_DATA     = 5'h10;

  localparam int unsigned CFG_LOOP_EN    = 1;
  localparam int unsigned CFG_ABORT_UR   = 2;
  localparam int unsigned CFG_MARK_IDLE  = 3;
  localparam int unsigned CFG_GO_ACTIVE  = 4;
  localparam int unsigned CFG_CRC_PRESET = 7;

  localparam int unsigned LST_ON_LOOP    = 1;
  localparam int unsigned LST_SENDING    = 4;
  localparam int unsigned LST_TX_FULL    = 8;

  localparam int unsigned EV_ABORT       = 0;
  localparam int unsigned EV_HUNT        = 1;
  localparam int unsigned EV_ON_LOOP     = 2;
  localparam int unsigned EV_SEND_DONE   = 3;
  localparam int unsigned EV_W           = 4;

  localparam logic [EV_W-1:0] RST_STATUS = 4'h0;
  localparam logic [EV_W-1:0] RST_MASK   = 4'h0;
  localparam logic [7:0]      RST_TXBUF  = 8'h00;

  localparam logic [7:0] FLAG_PATTERN = 8'h7e;
  localparam logic [7:0] EOP_PATTERN  = 8'hfe;
  localparam logic [2:0] ONES_BEFORE_SEVENTH = 3'h6;
  localparam logic [2:0] ONES_BEFORE_STUFF   = 3'h4;
  localparam logic [2:0] LAST_BIT_INDEX      = 3'h7;

  typedef struct packed {
    logic crc_preset;
    logic go_active;
    logic mark_idle;
    logic abort_ur;
    logic loop_en;
  } loop_cfg_t;

  localparam loop_cfg_t RST_CFG = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_GATE  = 3'b001,
    ST_HUNT  = 3'b010,
    ST_SYNC  = 3'b011,
    ST_READY = 3'b100,
    ST_SEND  = 3'b101,
    ST_EXIT  = 3'b110
  } loop_state_t;

endpackage : loop_ctl_pkg

// *** logic/loop_ctl.sv ***
/*
  Loop (ring) mode control of a bit-oriented serial channel acting as a secondary
  station: going on the loop, one-bit repeating, turning an end-of-poll into a flag,
  sending and closing frames, and leaving the loop.
  Assumes one 200 MHz clock, a bit clock and serial input arriving asynchronously,
  and an Avalon-MM master that honours waitrequest.
*/
// Summary of operation
// - Loop enable at bit 1, go-active-on-poll at bit 4 of loop configuration.
// - Loop status shows on-loop at bit 1 and loop-sending at bit 4.
// - Loop enable alone repeats input to output and preloads a flag to send.
// - With go-active, seven ones set abort, insert one-bit delay, set on-loop, hunt.
// - Sending needs a hunt-ending flag and then an end-of-poll 11111110 first.
// - Go-active on loop turns next end-of-poll into flag; sets abort, hunt, sending.
// - Early data gets one flag after the converted end-of-poll; else flags until data.
// - Go-active cleared before last byte; frame closes with one flag, repeating resumes.
// - Loop-sending clears after the closing flag has been shifted out.
// - Go-active still set at frame end keeps flags going until data or clear.
// - Abort-on-underrun and mark-idle settings are ignored in loop operation.
// - Loop enable cleared on loop: once any send has ended, seven ones end loop mode, set abort and hunt, clear on-loop.
// - Setting go-active is what enables the search for loop entry.
module loop_ctl #(
  parameter int unsigned ADDR_W = 5
) (
  input  wire logic              core_clk,      // 200 MHz core clock
  input  wire logic              rstn,          // asynchronous reset, active low
  input  wire logic [ADDR_W-1:0] address,       // Avalon byte address
  input  wire logic              read,          // Avalon read request
  input  wire logic              write,         // Avalon write request
  input  wire logic [31:0]       writedata,     // Avalon write data
  input  wire logic [3:0]        byteenable,    // Avalon byte enables
  output logic      [31:0]       readdata,      // Avalon read data
  output logic                   waitrequest,   // Avalon wait request
  input  wire logic              bit_clk,       // serial bit clock pin
  input  wire logic              serial_in,     // serial data from upstream
  output logic                   serial_out,    // serial data to downstream
  output logic                   irq            // level interrupt, active high
);

  if (ADDR_W < 5) begin : g_addr_check
    $error("ADDR_W must be at least 5");
  end

  logic                   rst_s1_ff;
  logic                   rst_n_ff;
  logic                   bclk_s1_ff;
  logic                   bclk_s2_ff;
  logic                   bclk_s3_ff;
  logic                   rxd_s1_ff;
  logic                   rxd_s2_ff;
  logic                   bit_stb;
  logic [7:0]             rx_sr_ff;
  logic [7:0]             nxt_rx_sr;
  logic [2:0]             ones_ff;
  logic                   rx_seven;
  logic                   delay_ff;
  loop_ctl_pkg::loop_state_t state_ff;
  loop_ctl_pkg::loop_state_t nxt_state;
  logic                   on_loop_ff;
  logic                   sending_ff;
  loop_ctl_pkg::loop_cfg_t cfg_ff;
  logic [loop_ctl_pkg::EV_W-1:0] status_ff;
  logic [loop_ctl_pkg::EV_W-1:0] mask_ff;
  logic [loop_ctl_pkg::EV_W-1:0] ev;
  logic [7:0]             txbuf_ff;
  logic                   txfull_ff;
  logic [7:0]             tx_sr_ff;
  logic [2:0]             tx_cnt_ff;
  logic [2:0]             tx_ones_ff;
  logic                   tx_data_ff;
  logic                   tx_stuff_ff;
  logic                   in_frame_ff;
  logic                   end_pend_ff;
  logic                   tx_bit_ff;
  logic                   tx_boundary;
  logic                   tx_load;
  logic                   eop_seen;
  logic                   bus_wr;
  logic                   wr_lane0;

  // Reset release is synchronised so that every flop leaves reset on the same edge.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bclk_s1_ff <= 1'b0;
      bclk_s2_ff <= 1'b0;
      bclk_s3_ff <= 1'b0;
      rxd_s1_ff  <= 1'b1;
      rxd_s2_ff  <= 1'b1;
    end else begin
      bclk_s1_ff <= bit_clk;
      bclk_s2_ff <= bclk_s1_ff;
      bclk_s3_ff <= bclk_s2_ff;
      rxd_s1_ff  <= serial_in;
      rxd_s2_ff  <= rxd_s1_ff;
    end
  end

  // Bits are taken on the rising bit clock; the bit clock must be well below core_clk/4.
  assign bit_stb   = bclk_s2_ff & ~bclk_s3_ff;
  assign nxt_rx_sr = {rxd_s2_ff, rx_sr_ff[7:1]};
  assign rx_seven  = bit_stb & rxd_s2_ff & (ones_ff == loop_ctl_pkg::ONES_BEFORE_SEVENTH);
  assign eop_seen  = bit_stb & (nxt_rx_sr == loop_ctl_pkg::EOP_PATTERN);

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_sr_ff <= 8'h00;
      ones_ff  <= 3'h0;
      delay_ff <= 1'b1;
    end else if (bit_stb) begin
      rx_sr_ff <= nxt_rx_sr;
      delay_ff <= rxd_s2_ff;
      if (!rxd_s2_ff) begin
        ones_ff <= 3'h0;
      end else if (ones_ff != 3'h7) begin
        ones_ff <= ones_ff + 3'h1;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    ev        = '0;
    case (state_ff)
      loop_ctl_pkg::ST_IDLE: begin
        if (cfg_ff.loop_en) begin
          nxt_state = loop_ctl_pkg::ST_GATE;
        end
      end
      loop_ctl_pkg::ST_GATE: begin
        if (!cfg_ff.loop_en) begin
          nxt_state = loop_ctl_pkg::ST_IDLE;
        end else if (cfg_ff.go_active && rx_seven) begin
          nxt_state                     = loop_ctl_pkg::ST_HUNT;
          ev[loop_ctl_pkg::EV_ABORT]    = 1'b1;
          ev[loop_ctl_pkg::EV_HUNT]     = 1'b1;
          ev[loop_ctl_pkg::EV_ON_LOOP]  = 1'b1;
        end
      end
      loop_ctl_pkg::ST_HUNT: begin
        if (!cfg_ff.loop_en) begin
          nxt_state = loop_ctl_pkg::ST_EXIT;
        end else if (bit_stb && nxt_rx_sr == loop_ctl_pkg::FLAG_PATTERN) begin
          nxt_state = loop_ctl_pkg::ST_SYNC;
        end
      end
      loop_ctl_pkg::ST_SYNC: begin
        if (!cfg_ff.loop_en) begin
          nxt_state = loop_ctl_pkg::ST_EXIT;
        end else if (eop_seen) begin
          nxt_state = loop_ctl_pkg::ST_READY;
        end
      end
      loop_ctl_pkg::ST_READY: begin
        if (!cfg_ff.loop_en) begin
          nxt_state = loop_ctl_pkg::ST_EXIT;
        end else if (cfg_ff.go_active && eop_seen) begin
          nxt_state                  = loop_ctl_pkg::ST_SEND;
          ev[loop_ctl_pkg::EV_ABORT] = 1'b1;
          ev[loop_ctl_pkg::EV_HUNT]  = 1'b1;
        end
      end
      loop_ctl_pkg::ST_SEND: begin
        if (bit_stb && end_pend_ff) begin
          nxt_state                      = loop_ctl_pkg::ST_READY;
          ev[loop_ctl_pkg::EV_SEND_DONE] = 1'b1;
        end
      end
      loop_ctl_pkg::ST_EXIT: begin
        if (rx_seven) begin
          nxt_state                  = loop_ctl_pkg::ST_IDLE;
          ev[loop_ctl_pkg::EV_ABORT] = 1'b1;
          ev[loop_ctl_pkg::EV_HUNT]  = 1'b1;
        end
      end
      default: begin
        nxt_state = loop_ctl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff   <= loop_ctl_pkg::ST_IDLE;
      on_loop_ff <= 1'b0;
      sending_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (ev[loop_ctl_pkg::EV_ON_LOOP]) begin
        on_loop_ff <= 1'b1;
      end else if (state_ff == loop_ctl_pkg::ST_EXIT && nxt_state == loop_ctl_pkg::ST_IDLE) begin
        on_loop_ff <= 1'b0;
      end
      if (state_ff == loop_ctl_pkg::ST_READY && nxt_state == loop_ctl_pkg::ST_SEND) begin
        sending_ff <= 1'b1;
      end else if (ev[loop_ctl_pkg::EV_SEND_DONE]) begin
        sending_ff <= 1'b0;
      end
    end
  end

  // The transmitter never consults abort-on-underrun or mark-idle: in loop operation an
  // underrun always closes with a flag and idle is always flags.
  assign tx_boundary = bit_stb && (state_ff == loop_ctl_pkg::ST_SEND) && !tx_stuff_ff
                       && (tx_cnt_ff == loop_ctl_pkg::LAST_BIT_INDEX);
  assign tx_load     = tx_boundary && txfull_ff;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tx_sr_ff    <= loop_ctl_pkg::FLAG_PATTERN;
      tx_cnt_ff   <= 3'h0;
      tx_ones_ff  <= 3'h0;
      tx_data_ff  <= 1'b0;
      tx_stuff_ff <= 1'b0;
      in_frame_ff <= 1'b0;
      end_pend_ff <= 1'b0;
      tx_bit_ff   <= 1'b0;
    end else if (state_ff != loop_ctl_pkg::ST_SEND) begin
      tx_sr_ff    <= loop_ctl_pkg::FLAG_PATTERN;
      tx_cnt_ff   <= 3'h0;
      tx_ones_ff  <= 3'h0;
      tx_data_ff  <= 1'b0;
      tx_stuff_ff <= 1'b0;
      in_frame_ff <= 1'b0;
      end_pend_ff <= 1'b0;
      // The first bit sent stands in for the last one of the received end-of-poll,
      // so the poll leaves this station as a flag.
      tx_bit_ff   <= 1'b0;
    end else if (bit_stb) begin
      if (tx_stuff_ff) begin
        tx_bit_ff   <= 1'b0;
        tx_stuff_ff <= 1'b0;
        tx_ones_ff  <= 3'h0;
      end else begin
        tx_bit_ff <= tx_sr_ff[0];
        tx_cnt_ff <= tx_cnt_ff + 3'h1;
        tx_sr_ff  <= {1'b0, tx_sr_ff[7:1]};
        if (tx_data_ff && tx_sr_ff[0]) begin
          tx_ones_ff  <= tx_ones_ff + 3'h1;
          tx_stuff_ff <= (tx_ones_ff == loop_ctl_pkg::ONES_BEFORE_STUFF);
        end else begin
          tx_ones_ff <= 3'h0;
        end
        if (tx_boundary) begin
          if (txfull_ff) begin
            tx_sr_ff    <= txbuf_ff;
            tx_data_ff  <= 1'b1;
            in_frame_ff <= 1'b1;
          end else if (in_frame_ff) begin
            tx_sr_ff    <= loop_ctl_pkg::FLAG_PATTERN;
            tx_data_ff  <= 1'b0;
            in_frame_ff <= 1'b0;
          end else if (!cfg_ff.go_active) begin
            end_pend_ff <= 1'b1;
          end else begin
            tx_sr_ff   <= loop_ctl_pkg::FLAG_PATTERN;
            tx_data_ff <= 1'b0;
          end
        end
      end
    end
  end

  // Before loop enable and after loop exit the line idles at mark; the gate state is a straight repeat.
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      serial_out <= 1'b1;
    end else begin
      case (state_ff)
        loop_ctl_pkg::ST_IDLE: serial_out <= 1'b1;
        loop_ctl_pkg::ST_GATE: serial_out <= rxd_s2_ff;
        loop_ctl_pkg::ST_SEND: serial_out <= tx_bit_ff;
        default:               serial_out <= delay_ff;
      endcase
    end
  end

  function automatic logic [31:0] reg_read(
    input logic [ADDR_W-1:0]           addr,
    input loop_ctl_pkg::loop_cfg_t     cfg,
    input logic                        on_loop,
    input logic                        sending,
    input logic                        txfull,
    input logic [loop_ctl_pkg::EV_W-1:0] status,
    input logic [loop_ctl_pkg::EV_W-1:0] mask
  );
    logic [31:0] val;
    val = 32'h0000_0000;
    case (addr)
      ADDR_W'(loop_ctl_pkg::OFF_LOOP_CONFIG): begin
        val[loop_ctl_pkg::CFG_LOOP_EN]    = cfg.loop_en;
        val[loop_ctl_pkg::CFG_ABORT_UR]   = cfg.abort_ur;
        val[loop_ctl_pkg::CFG_MARK_IDLE]  = cfg.mark_idle;
        val[loop_ctl_pkg::CFG_GO_ACTIVE]  = cfg.go_active;
        val[loop_ctl_pkg::CFG_CRC_PRESET] = cfg.crc_preset;
      end
      ADDR_W'(loop_ctl_pkg::OFF_LOOP_STATUS): begin
        val[loop_ctl_pkg::LST_ON_LOOP] = on_loop;
        val[loop_ctl_pkg::LST_SENDING] = sending;
        val[loop_ctl_pkg::LST_TX_FULL] = txfull;
      end
      ADDR_W'(loop_ctl_pkg::OFF_MAIN_STATUS): val[loop_ctl_pkg::EV_W-1:0] = status;
      ADDR_W'(loop_ctl_pkg::OFF_IRQ_MASK):    val[loop_ctl_pkg::EV_W-1:0] = mask;
      default:                                val = 32'h0000_0000;
    endcase
    return val;
  endfunction : reg_read

  // Every access takes one wait cycle; the write lands on the edge where the master
  // sees waitrequest low, so it is never applied twice.
  assign bus_wr   = write && !waitrequest;
  assign wr_lane0 = bus_wr && byteenable[0];

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= reg_read(address, cfg_ff, on_loop_ff, sending_ff, txfull_ff,
                              status_ff, mask_ff);
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cfg_ff  <= loop_ctl_pkg::RST_CFG;
      mask_ff <= loop_ctl_pkg::RST_MASK;
    end else if (wr_lane0) begin
      if (address == ADDR_W'(loop_ctl_pkg::OFF_LOOP_CONFIG)) begin
        cfg_ff.loop_en    <= writedata[loop_ctl_pkg::CFG_LOOP_EN];
        cfg_ff.abort_ur   <= writedata[loop_ctl_pkg::CFG_ABORT_UR];
        cfg_ff.mark_idle  <= writedata[loop_ctl_pkg::CFG_MARK_IDLE];
        cfg_ff.go_active  <= writedata[loop_ctl_pkg::CFG_GO_ACTIVE];
        cfg_ff.crc_preset <= writedata[loop_ctl_pkg::CFG_CRC_PRESET];
      end
      if (address == ADDR_W'(loop_ctl_pkg::OFF_IRQ_MASK)) begin
        mask_ff <= writedata[loop_ctl_pkg::EV_W-1:0];
      end
    end
  end

  // A new event outranks a write-one-to-clear in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      status_ff <= loop_ctl_pkg::RST_STATUS;
      irq       <= 1'b0;
    end else begin
      if (wr_lane0 && address == ADDR_W'(loop_ctl_pkg::OFF_MAIN_STATUS)) begin
        status_ff <= (status_ff & ~writedata[loop_ctl_pkg::EV_W-1:0]) | ev;
      end else begin
        status_ff <= status_ff | ev;
      end
      irq <= |(status_ff & mask_ff);
    end
  end

  // A full buffer is overwritten by a second write; software should wait for it to empty.
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      txbuf_ff  <= loop_ctl_pkg::RST_TXBUF;
      txfull_ff <= 1'b0;
    end else if (wr_lane0 && address == ADDR_W'(loop_ctl_pkg::OFF_TX_DATA)) begin
      txbuf_ff  <= writedata[7:0];
      txfull_ff <= 1'b1;
    end else if (tx_load) begin
      txfull_ff <= 1'b0;
    end
  end

  property p_enter_loop;
    @(posedge core_clk) disable iff (!rst_n_ff)
      (state_ff == loop_ctl_pkg::ST_GATE && cfg_ff.loop_en && cfg_ff.go_active && rx_seven)
      |=> on_loop_ff && state_ff == loop_ctl_pkg::ST_HUNT
          && status_ff[loop_ctl_pkg::EV_ABORT];
  endproperty
  a_enter_loop: assert property (p_enter_loop) else $error("loop entry not taken");

  property p_gate_repeat;
    @(posedge core_clk) disable iff (!rst_n_ff)
      (state_ff == loop_ctl_pkg::ST_GATE) |=> serial_out == $past(rxd_s2_ff);
  endproperty
  a_gate_repeat: assert property (p_gate_repeat) else $error("gate path broken");

  property p_one_bit_delay;
    @(posedge core_clk) disable iff (!rst_n_ff)
      (state_ff == loop_ctl_pkg::ST_READY && bit_stb && nxt_state == loop_ctl_pkg::ST_READY)
      |=> ##1 serial_out == $past(rxd_s2_ff, 2);
  endproperty
  a_one_bit_delay: assert property (p_one_bit_delay) else $error("delay bit wrong");

  property p_no_send_early;
    @(posedge core_clk) disable iff (!rst_n_ff)
      (state_ff == loop_ctl_pkg::ST_HUNT || state_ff == loop_ctl_pkg::ST_SYNC)
      |=> state_ff != loop_ctl_pkg::ST_SEND;
  endproperty
  a_no_send_early: assert property (p_no_send_early) else $error("sent before sync");

  property p_start_send;
    @(posedge core_clk) disable iff (!rst_n_ff)
      (state_ff == loop_ctl_pkg::ST_READY && cfg_ff.loop_en && cfg_ff.go_active && eop_seen)
      |=> sending_ff && status_ff[loop_ctl_pkg::EV_ABORT] && status_ff[loop_ctl_pkg::EV_HUNT];
  endproperty
  a_start_send: assert property (p_start_send) else $error("poll not answered");

  property p_send_end;
    @(posedge core_clk) disable iff (!rst_n_ff)
      $fell(sending_ff) |-> state_ff == loop_ctl_pkg::ST_READY && !$past(in_frame_ff);
  endproperty
  a_send_end: assert property (p_send_end) else $error("sending cleared mid frame");

  property p_keep_flags;
    @(posedge core_clk) disable iff (!rst_n_ff)
      (tx_boundary && !txfull_ff && !in_frame_ff && cfg_ff.go_active)
      |=> sending_ff && tx_sr_ff == loop_ctl_pkg::FLAG_PATTERN && !end_pend_ff;
  endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("flag fill missing");

  property p_leave_loop;
    @(posedge core_clk) disable iff (!rst_n_ff)
      (state_ff == loop_ctl_pkg::ST_EXIT && rx_seven)
      |=> !on_loop_ff && status_ff[loop_ctl_pkg::EV_HUNT] ##1 serial_out;
  endproperty
  a_leave_loop: assert property (p_leave_loop) else $error("loop exit wrong");

  property p_irq_level;
    @(posedge core_clk) disable iff (!rst_n_ff)
      ##1 irq == |($past(status_ff) & $past(mask_ff));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

endmodule : loop_ctl

// *** dv/loop_peer.sv ***
/*
  Upstream loop peer: sends bytes LSB first on its own bit clock and records
  the station's serial output just before each rising bit clock edge.
  Assumes the station takes bits on the rising edge of bit_clk.
*/
module loop_peer (
  output logic      bit_clk,    // bit clock to the station
  output logic      serial_in,  // data to the station
  input  wire logic serial_out  // data repeated or sent by the station
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [255:0] hist;

  initial begin
    bit_clk = 1'b0;
    serial_in = 1'b1;
    hist = '0;
  end

  // The clock stands still between calls, and the line is then turned over
  // so that a stale level is never mistaken for a held bit.
  task automatic send(input logic [7:0] b, input int n);
    #1;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        serial_in = b[i];
        #40;
        hist = {hist[254:0], serial_out};
        bit_clk = 1'b1;
        #40;
        bit_clk = 1'b0;
      end
    end
    #40;
    serial_in = ~serial_in;
  endtask : send
endmodule : loop_peer

// *** dv/testbench.sv ***
/*
  Self-checking bench: register access, loop entry, one-bit repeating,
  poll-driven sending with flags, interrupt and orderly exit.
  Assumes the peer model drives the bit clock and serial input.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rstn;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        bit_clk;
  logic        serial_in;
  logic        serial_out;
  logic        irq;
  logic [31:0] rd;
  int          n_mismatch;
  int          tests_run;

  loop_ctl loop_ctl_i (.core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .bit_clk(bit_clk), .serial_in(serial_in),
    .serial_out(serial_out), .irq(irq));
  loop_peer loop_peer_i (.bit_clk(bit_clk), .serial_in(serial_in), .serial_out(serial_out));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be = 4'hf);
    @(posedge core_clk);
    address <= a;
    write <= wr_en;
    read <= ~wr_en;
    writedata <= d;
    byteenable <= be;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rdc

  // Bit 0 of the pattern is the earliest bit on the line.
  function automatic logic [31:0] find(input logic [31:0] p);
    logic hit;
    find = 32'h0;
    for (int i = 0; i <= 224; i++) begin
      hit = 1'b1;
      for (int j = 0; j < 32; j++) if (loop_peer_i.hist[i+31-j] !== p[j]) hit = 1'b0;
      if (hit) find = 32'h1;
    end
  endfunction : find

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic t_reset;
    check(serial_out, 32'h1);
    rdc(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'hff, 32'h0);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'hfff, 32'h0);
    rdc(loop_ctl_pkg::OFF_MAIN_STATUS, 32'hf, 32'h0);
    wr(5'h14, 32'hff);
    rdc(5'h14, 32'hffffffff, 32'h0);
    bus(1'b1, loop_ctl_pkg::OFF_IRQ_MASK, 32'hf, 4'he);
    rdc(loop_ctl_pkg::OFF_IRQ_MASK, 32'hf, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_gate;
    wr(loop_ctl_pkg::OFF_IRQ_MASK, 32'h8);
    rdc(loop_ctl_pkg::OFF_IRQ_MASK, 32'hf, 32'h8);
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h80);
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h82);
    rdc(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'hff, 32'h82);
    loop_peer_i.send(8'h35, 1);
    check({24'h0, loop_peer_i.hist[7:0]}, 32'hac);
    $display("test gate done");
  endtask : t_gate

  task automatic t_enter;
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h92);
    loop_peer_i.send(8'hff, 1);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h12, 32'h2);
    rdc(loop_ctl_pkg::OFF_MAIN_STATUS, 32'hf, 32'h7);
    check(irq, 32'h0);
    wr(loop_ctl_pkg::OFF_MAIN_STATUS, 32'hf);
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h82);
    loop_peer_i.send(8'h7e, 1);
    loop_peer_i.send(8'h35, 1);
    check({25'h0, loop_peer_i.hist[6:0]}, 32'h56);
    loop_peer_i.send(8'hfe, 1);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h12, 32'h2);
    $display("test enter done");
  endtask : t_enter

  task automatic t_reply;
    loop_peer_i.hist = '0;
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h92);
    wr(loop_ctl_pkg::OFF_TX_DATA, 32'h5a);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h112, 32'h102);
    loop_peer_i.send(8'hfe, 1);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h12, 32'h12);
    rdc(loop_ctl_pkg::OFF_MAIN_STATUS, 32'hf, 32'h3);
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h82);
    loop_peer_i.send(8'h00, 6);
    check(find(32'h7e5a7e7e), 32'h1);
    check(find(32'h5a7e7e7e), 32'h0);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h12, 32'h2);
    check(irq, 32'h1);
    wr(loop_ctl_pkg::OFF_MAIN_STATUS, 32'hf);
    rdc(loop_ctl_pkg::OFF_MAIN_STATUS, 32'hf, 32'h0);
    check(irq, 32'h0);
    loop_peer_i.send(8'h35, 1);
    check({25'h0, loop_peer_i.hist[6:0]}, 32'h56);
    $display("test reply done");
  endtask : t_reply

  task automatic t_flags;
    loop_peer_i.hist = '0;
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h9e);
    loop_peer_i.send(8'hfe, 1);
    loop_peer_i.send(8'h00, 4);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h12, 32'h12);
    check(find(32'h7e7e7e7e), 32'h1);
    wr(loop_ctl_pkg::OFF_TX_DATA, 32'h5a);
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h8e);
    loop_peer_i.send(8'h00, 6);
    check(find(32'h7e5a7e7e), 32'h1);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h12, 32'h2);
    $display("test flags done");
  endtask : t_flags

  task automatic t_exit;
    wr(loop_ctl_pkg::OFF_MAIN_STATUS, 32'hf);
    wr(loop_ctl_pkg::OFF_LOOP_CONFIG, 32'h00);
    loop_peer_i.send(8'hff, 2);
    rdc(loop_ctl_pkg::OFF_LOOP_STATUS, 32'h12, 32'h0);
    rdc(loop_ctl_pkg::OFF_MAIN_STATUS, 32'h3, 32'h3);
    check(serial_out, 32'h1);
    $display("test exit done");
  endtask : t_exit

  initial begin
    #300us;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    rstn = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset;
    t_gate;
    t_enter;
    t_reply;
    t_flags;
    t_exit;
    wrap_up;
  end
endmodule : testbench
